// ### dac_cfg_pkg.sv
// Constants for the channel configuration and software command decoder
package dac_cfg_pkg;

	// ************************************************************
	// Frame layout: two channel address bits, then a 16-bit word
	// ************************************************************
	localparam int unsigned FRAME_BITS    = 18;
	localparam int unsigned CNT_W         = 5;
	localparam logic [4:0]  FRAME_LEN     = 5'h12;
	localparam int unsigned CHAN_HI       = 17;
	localparam int unsigned CHAN_LO       = 16;
	localparam int unsigned SEL_HI        = 15;
	localparam int unsigned SEL_LO        = 13;

	// ************************************************************
	// Register select codes in bits 15..13 of the word
	// ************************************************************
	localparam logic [2:0]  SEL_CHANNEL_CONTROL   = 3'h2;
	localparam logic [2:0]  SEL_SOFTWARE_COMMAND  = 3'h4;

	// ************************************************************
	// Channel control field positions and reset values
	// ************************************************************
	localparam int unsigned POS_OUTPUT_ON = 6;
	localparam int unsigned POS_SENSE_SEL = 5;
	localparam int unsigned POS_BOOST     = 4;
	localparam int unsigned POS_RANGE_HI  = 2;
	localparam int unsigned POS_RANGE_LO  = 0;
	localparam logic        RST_SENSE_SEL = 1'b0;
	localparam logic        RST_BOOST     = 1'b0;
	localparam logic        RST_OUTPUT_ON = 1'b0;
	localparam logic [2:0]  RST_RANGE     = 3'h4;

	// ************************************************************
	// Range codes
	// ************************************************************
	localparam logic [2:0]  RANGE_4_20    = 3'h4;
	localparam logic [2:0]  RANGE_0_20    = 3'h5;
	localparam logic [2:0]  RANGE_0_24    = 3'h6;

	// ************************************************************
	// Software command fields and codes
	// ************************************************************
	localparam int unsigned POS_USER_BIT  = 12;
	localparam logic [11:0] CODE_RESET    = 12'h555;
	localparam logic [11:0] CODE_SERVICE  = 12'h195;
	localparam logic        RST_USER_BIT  = 1'b0;

	// ************************************************************
	// Watchdog timing
	// ************************************************************
	localparam int unsigned CLK_HZ        = 25000000;
	localparam int unsigned WDOG_MS       = 5;
	localparam int unsigned WDOG_CYCLES   = (CLK_HZ / 1000) * WDOG_MS;
	localparam int unsigned WDOG_W        = 24;

endpackage

// ### dac_channel_config_and_soft_reg.sv
// Serial-written channel configuration and software command register block
// What this block does
// R1: Sense resistor select bit: 0 external (reset), 1 internal.
// R2: Per-channel boost power bit: 0 powered down (reset), 1 powered up.
// R3: One global bit powers up all boost converters together.
// R4: Host clears the channel output enable before powering its boost down. The block does not check or enforce this order.
// R5: Range 100 is 4-20 mA, 101 0-20 mA, 110 0-24 mA; others reserved.
// R6: The proper code in the software register resets the whole part.
// R7: Reset code is 0x555 in the twelve low software register bits.
// R8: Software register bit 12 is mirrored onto the user_toggle_o output.
// R9: With watchdog on, host writes 0x195 before each timeout.
// R10: Missing service code within the timeout raises the alert output.
// R11: Service code is required only while the watchdog is enabled.
// R12: Other software writes only update the mirrored user bit.
`timescale 1ns/1ns
module dac_channel_config_and_soft_reg #(
	parameter int unsigned WDOG_TIMEOUT = dac_cfg_pkg::WDOG_CYCLES
) (
	// Clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// Serial link pins
	input  wire logic        serial_clk_i,
	input  wire logic        serial_frame_n_i,
	input  wire logic        serial_in_pin_i,
	// Main control inputs
	input  wire logic        all_boost_power_up_i,
	input  wire logic        watchdog_enable_i,
	// Per-channel configuration
	output logic [3:0]       sense_resistor_select_o,
	output logic [3:0]       boost_power_up_o,
	output logic [3:0]       channel_output_on_o,
	output logic [11:0]      output_range_code_o,
	// Status and events
	output logic             user_toggle_o,
	output logic             alert_o,
	output logic             soft_reset_o
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic       sclk_prev_q;
	logic       frame_prev_q;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta_q       <= 3'h7;
			sync_q       <= 3'h7;
			sclk_prev_q  <= 1'b1;
			frame_prev_q <= 1'b1;
		end
		else if (ce_i)
		begin
			meta_q       <= {serial_clk_i, serial_frame_n_i, serial_in_pin_i};
			sync_q       <= meta_q;
			sclk_prev_q  <= sync_q[2];
			frame_prev_q <= sync_q[1];
		end
	end

	logic sclk_fall;
	logic frame_end;
	logic in_frame;
	assign in_frame  = !sync_q[1];
	// Data is taken on the falling serial clock edge, frame closes on rising frame line
	assign sclk_fall = sclk_prev_q && !sync_q[2] && in_frame;
	assign frame_end = !frame_prev_q && sync_q[1];

	// ************************************************************
	// Shift register
	// ************************************************************
	typedef enum logic [1:0] {
		LINK_IDLE  = 2'b01,
		LINK_SHIFT = 2'b10
	} link_state_t;

	link_state_t                             link_q, link_d;
	logic [dac_cfg_pkg::FRAME_BITS-1:0]      shift_q, shift_d;
	logic [dac_cfg_pkg::CNT_W-1:0]           cnt_q, cnt_d;
	logic                                    commit;

	always_comb
	begin
		link_d  = link_q;
		shift_d = shift_q;
		cnt_d   = cnt_q;
		commit  = 1'b0;
		case (link_q)
			LINK_IDLE:
			begin
				cnt_d = '0;
				if (in_frame)
				begin
					link_d = LINK_SHIFT;
				end
			end
			LINK_SHIFT:
			begin
				if (sclk_fall)
				begin
					shift_d = {shift_q[dac_cfg_pkg::FRAME_BITS-2:0], sync_q[0]};
					if (cnt_q != 5'h1F)
					begin
						cnt_d = cnt_q + 5'h01;
					end
				end
				if (frame_end)
				begin
					// Short or long frames are dropped whole
					commit = (cnt_q == dac_cfg_pkg::FRAME_LEN);
					link_d = LINK_IDLE;
				end
			end
			default:
			begin
				link_d = LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			link_q  <= LINK_IDLE;
			shift_q <= '0;
			cnt_q   <= '0;
		end
		else if (ce_i)
		begin
			link_q  <= link_d;
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
		end
	end

	// ************************************************************
	// Register decode
	// ************************************************************
	logic [1:0]  chan;
	logic [2:0]  sel;
	logic [11:0] low_code;
	logic [2:0]  new_range;
	logic        wr_chan;
	logic        wr_soft;
	logic        do_reset;
	logic        do_service;
	assign chan       = shift_q[dac_cfg_pkg::CHAN_HI:dac_cfg_pkg::CHAN_LO];
	assign sel        = shift_q[dac_cfg_pkg::SEL_HI:dac_cfg_pkg::SEL_LO];
	assign low_code   = shift_q[11:0];
	assign new_range  = shift_q[dac_cfg_pkg::POS_RANGE_HI:dac_cfg_pkg::POS_RANGE_LO];
	assign wr_chan    = commit && (sel == dac_cfg_pkg::SEL_CHANNEL_CONTROL);
	assign wr_soft    = commit && (sel == dac_cfg_pkg::SEL_SOFTWARE_COMMAND);
	assign do_reset   = wr_soft && (low_code == dac_cfg_pkg::CODE_RESET);   // [R6] [R7]
	assign do_service = wr_soft && (low_code == dac_cfg_pkg::CODE_SERVICE); // [R9]

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic [3:0]  sense_q, sense_d;
	logic [3:0]  boost_q, boost_d;
	logic [3:0]  out_on_q, out_on_d;
	logic [11:0] range_q, range_d;
	logic [3:0]  boost_out_q, boost_out_d;
	logic        user_q, user_d;
	logic        reset_pulse_q, reset_pulse_d;

	always_comb
	begin
		sense_d       = sense_q;
		boost_d       = boost_q;
		out_on_d      = out_on_q;
		range_d       = range_q;
		user_d        = user_q;
		reset_pulse_d = do_reset;
		if (do_reset)
		begin
			// Software reset returns every field to its reset value
			sense_d  = {4{dac_cfg_pkg::RST_SENSE_SEL}};                  // [R6]
			boost_d  = {4{dac_cfg_pkg::RST_BOOST}};
			out_on_d = {4{dac_cfg_pkg::RST_OUTPUT_ON}};
			range_d  = {4{dac_cfg_pkg::RST_RANGE}};
			user_d   = dac_cfg_pkg::RST_USER_BIT;
		end
		else
		begin
			if (wr_soft)
			begin
				user_d = shift_q[dac_cfg_pkg::POS_USER_BIT];                // [R8] [R12]
			end
			if (wr_chan)
			begin
				sense_d[chan]  = shift_q[dac_cfg_pkg::POS_SENSE_SEL];       // [R1]
				boost_d[chan]  = shift_q[dac_cfg_pkg::POS_BOOST];           // [R2]
				out_on_d[chan] = shift_q[dac_cfg_pkg::POS_OUTPUT_ON];
				// Reserved range codes leave the channel's range unchanged
				if ((new_range == dac_cfg_pkg::RANGE_4_20) ||
					(new_range == dac_cfg_pkg::RANGE_0_20) ||
					(new_range == dac_cfg_pkg::RANGE_0_24))               // [R5]
				begin
					range_d[chan*3 +: 3] = new_range;
				end
			end
		end
		boost_out_d = boost_d | {4{all_boost_power_up_i}};                  // [R2] [R3]
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sense_q       <= {4{dac_cfg_pkg::RST_SENSE_SEL}};
			boost_q       <= {4{dac_cfg_pkg::RST_BOOST}};
			out_on_q      <= {4{dac_cfg_pkg::RST_OUTPUT_ON}};
			range_q       <= {4{dac_cfg_pkg::RST_RANGE}};
			boost_out_q   <= 4'h0;
			user_q        <= dac_cfg_pkg::RST_USER_BIT;
			reset_pulse_q <= 1'b0;
		end
		else if (ce_i)
		begin
			sense_q       <= sense_d;
			boost_q       <= boost_d;
			out_on_q      <= out_on_d;
			range_q       <= range_d;
			boost_out_q   <= boost_out_d;
			user_q        <= user_d;
			reset_pulse_q <= reset_pulse_d;
		end
	end

	// ************************************************************
	// Watchdog
	// ************************************************************
	logic [dac_cfg_pkg::WDOG_W-1:0] wdog_q, wdog_d;
	logic                           alert_q, alert_d;
	localparam logic [dac_cfg_pkg::WDOG_W-1:0] WDOG_LAST =
		dac_cfg_pkg::WDOG_W'(WDOG_TIMEOUT - 1);

	always_comb
	begin
		wdog_d  = wdog_q;
		alert_d = alert_q;
		// Disabled watchdog holds the count cleared and never faults
		if (!watchdog_enable_i || do_service || do_reset)                 // [R11]
		begin
			wdog_d = '0;
		end
		else if (wdog_q != WDOG_LAST)
		begin
			wdog_d = wdog_q + 1'b1;
		end
		if (do_reset || !watchdog_enable_i)
		begin
			alert_d = 1'b0;
		end
		else if (do_service)
		begin
			alert_d = 1'b0;
		end
		if (watchdog_enable_i && !do_service && !do_reset && (wdog_q == WDOG_LAST))
		begin
			alert_d = 1'b1;                                                 // [R10]
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wdog_q  <= '0;
			alert_q <= 1'b0;
		end
		else if (ce_i)
		begin
			wdog_q  <= wdog_d;
			alert_q <= alert_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign sense_resistor_select_o = sense_q;
	assign boost_power_up_o        = boost_out_q;
	assign channel_output_on_o     = out_on_q;
	assign output_range_code_o     = range_q;
	assign user_toggle_o           = user_q;
	assign alert_o                 = alert_q;
	assign soft_reset_o            = reset_pulse_q;

endmodule // dac_channel_config_and_soft_reg

// ### dac_cfg_host_model.sv
// Host side of the serial link: sends whole 18-bit frames
`timescale 1ns/1ns
module dac_cfg_host_model (
	// Bench clock
	input  wire logic clk_i,
	// Serial link pins
	output logic      serial_clk_o,
	output logic      serial_frame_n_o,
	output logic      serial_in_pin_o
);
	initial
	begin
		serial_clk_o = 1'b1;
		serial_frame_n_o = 1'b1;
		serial_in_pin_o = 1'b0;
	end

	// Four cycles a phase gives the 320 ns link clock
	task automatic half();
		repeat (4) @(negedge clk_i);
	endtask

	// Link clock stands high between frames; data moves while it is high
	task automatic send(input logic [17:0] w);
		serial_frame_n_o = 1'b0;
		for (int i = 17; i >= 0; i--)
		begin
			serial_in_pin_o = w[i];
			half();
			serial_clk_o = 1'b0;
			half();
			serial_clk_o = 1'b1;
		end
		half();
		serial_frame_n_o = 1'b1;
		// Released line must not keep showing the last bit
		serial_in_pin_o = ~serial_in_pin_o;
		half();
	endtask
endmodule // dac_cfg_host_model

// ### dac_channel_config_and_soft_reg_monitor.sv
// Port checker for the configuration block, bound to its top
`timescale 1ns/1ns
module dac_cfg_monitor #(
	parameter int unsigned WDOG_TIMEOUT = 50
) (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        ce_i,
	input wire logic        serial_frame_n_i,
	input wire logic        all_boost_power_up_i,
	input wire logic        watchdog_enable_i,
	input wire logic [3:0]  sense_resistor_select_o,
	input wire logic [3:0]  boost_power_up_o,
	input wire logic [3:0]  channel_output_on_o,
	input wire logic [11:0] output_range_code_o,
	input wire logic        user_toggle_o,
	input wire logic        alert_o,
	input wire logic        soft_reset_o
);
	// ****
	// Cycles since the last frame end, and since the last frame end or watchdog enable
	// ****
	logic        fr_q;
	logic        rise;
	logic [3:0]  since_q;
	logic [19:0] idle_q;

	assign rise = !fr_q && serial_frame_n_i;

	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i)
		begin
			fr_q <= 1'b1;
			since_q <= 4'hF;
			idle_q <= 20'h0;
		end
		else
		begin
			fr_q <= serial_frame_n_i;
			since_q <= rise ? 4'h0 : since_q + 4'(since_q != 4'hF);
			idle_q <= (rise || !watchdog_enable_i) ? 20'h0 : idle_q + 20'h1;
		end

	function automatic logic ok3(input logic [11:0] c);
		ok3 = 1'b1;
		for (int i = 0; i < 4; i++)
			ok3 &= c[i*3 +: 3] inside {3'h4, 3'h5, 3'h6};
	endfunction

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_range_legal: assert property (ok3(output_range_code_o))
		else $error("range code reserved");
	a_boost_global: assert property (all_boost_power_up_i && ce_i |=> boost_power_up_o == 4'hF)
		else $error("global boost ignored");
	a_pulse_single: assert property (soft_reset_o |=> !soft_reset_o)
		else $error("reset pulse too long");
	a_pulse_framed: assert property (soft_reset_o |-> since_q <= 4'h7)
		else $error("reset pulse without frame");
	a_reset_clears: assert property (soft_reset_o |-> ##[0:1] (
		sense_resistor_select_o == 4'h0 && channel_output_on_o == 4'h0
		&& output_range_code_o == 12'h924 && !user_toggle_o))
		else $error("fields not reset");
	a_cfg_framed: assert property ($changed({sense_resistor_select_o,
		channel_output_on_o, output_range_code_o, user_toggle_o}) |-> since_q <= 4'h7)
		else $error("field changed without frame");
	a_boost_cause: assert property ($changed(boost_power_up_o) |-> since_q <= 4'h7
		|| $past(all_boost_power_up_i) != $past(all_boost_power_up_i, 2))
		else $error("boost changed without cause");
	a_alert_off: assert property (!watchdog_enable_i |=> !alert_o)
		else $error("alert while watchdog off");
	a_alert_due: assert property (idle_q == 20'(WDOG_TIMEOUT + 6) |-> alert_o)
		else $error("alert missing after timeout");

	c_soft_reset: cover property (soft_reset_o);
	c_alert: cover property ($rose(alert_o));
	c_user: cover property ($rose(user_toggle_o));
endmodule // dac_cfg_monitor

bind dac_channel_config_and_soft_reg dac_cfg_monitor #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) mon (
	.clk_i, .rstn_i, .ce_i, .serial_frame_n_i, .all_boost_power_up_i, .watchdog_enable_i,
	.sense_resistor_select_o, .boost_power_up_o, .channel_output_on_o, .output_range_code_o,
	.user_toggle_o, .alert_o, .soft_reset_o
);

// ### dac_channel_config_and_soft_reg_test.sv
// Self-checking bench for the configuration block
`timescale 1ns/1ns
module dac_channel_config_and_soft_reg_test;
	localparam int unsigned TO = 400;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        ce_i = 1'b1;
	logic        all_boost_power_up_i = 1'b0;
	logic        watchdog_enable_i = 1'b0;
	logic        serial_clk_i, serial_frame_n_i, serial_in_pin_i;
	logic [3:0]  sense_resistor_select_o, boost_power_up_o, channel_output_on_o;
	logic [11:0] output_range_code_o;
	logic        user_toggle_o, alert_o, soft_reset_o;
	logic [3:0]  e_sense = 4'h0, e_boost = 4'h0, e_on = 4'h0;
	logic [11:0] e_rng = 12'h924;
	logic        e_user = 1'b0;
	int          err_count = 0, checks = 0, cyc = 0, pulses = 0;

	always #20 clk_i = ~clk_i;

	dac_cfg_host_model host (
		.clk_i            (clk_i),
		.serial_clk_o     (serial_clk_i),
		.serial_frame_n_o (serial_frame_n_i),
		.serial_in_pin_o  (serial_in_pin_i)
	);

	dac_channel_config_and_soft_reg #(.WDOG_TIMEOUT(TO)) uut (
		.clk_i, .rstn_i, .ce_i, .serial_clk_i, .serial_frame_n_i, .serial_in_pin_i,
		.all_boost_power_up_i, .watchdog_enable_i, .sense_resistor_select_o,
		.boost_power_up_o, .channel_output_on_o, .output_range_code_o,
		.user_toggle_o, .alert_o, .soft_reset_o
	);

	// ****
	// Checking and access tasks
	// ****
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// A one-cycle pulse always spans exactly one falling edge
	always @(negedge clk_i)
	begin
		cyc++;
		if (soft_reset_o === 1'b1)
			pulses++;
		if (cyc == 10000)
		begin
			err_count++;
			$display("ERROR %0t: timeout", $time);
			tally_and_finish();
		end
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_all();
		chk(12'(sense_resistor_select_o), 12'(e_sense));
		chk(12'(boost_power_up_o), 12'(e_boost));
		chk(12'(channel_output_on_o), 12'(e_on));
		chk(output_range_code_o, e_rng);
		chk(12'(user_toggle_o), 12'(e_user));
	endtask

	task automatic wr(input logic [1:0] ch, input logic [2:0] sel, input logic [12:0] pl);
		host.send({ch, sel, pl});
		repeat (6) @(negedge clk_i);
	endtask

	task automatic ctl(input logic [1:0] ch, input logic o, s, b, input logic [2:0] r);
		wr(ch, dac_cfg_pkg::SEL_CHANNEL_CONTROL, {6'h0, o, s, b, 1'b0, r});
		e_on[ch] = o;
		e_sense[ch] = s;
		e_boost[ch] = b;
		if (r inside {3'h4, 3'h5, 3'h6})
			e_rng[ch*3 +: 3] = r;
		chk_all();
	endtask

	task automatic sw(input logic u, input logic [11:0] c);
		int p;
		p = pulses;
		wr(2'h0, dac_cfg_pkg::SEL_SOFTWARE_COMMAND, {u, c});
		chk(12'(pulses - p), 12'(c == 12'h555));
		e_user = u;
		if (c == 12'h555)
			{e_sense, e_boost, e_on, e_rng, e_user} = {12'h0, 12'h924, 1'b0};
		chk_all();
	endtask

	initial
	begin
		repeat (8) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		chk_all();
		ctl(2'h2, 1'b1, 1'b1, 1'b1, 3'h5);
		for (int r = 0; r < 8; r++)
			ctl(2'h1, 1'b0, r[0], 1'b0, 3'(r));
		ctl(2'h2, 1'b0, 1'b1, 1'b1, 3'h6);
		ctl(2'h2, 1'b0, 1'b1, 1'b0, 3'h6);
		all_boost_power_up_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk(12'(boost_power_up_o), 12'hF);
		all_boost_power_up_i = 1'b0;
		repeat (2) @(negedge clk_i);
		chk_all();
		sw(1'b1, 12'h000);
		sw(1'b0, 12'h554);
		sw(1'b1, 12'h555);
		watchdog_enable_i = 1'b1;
		sw(1'b0, 12'h195);
		sw(1'b0, 12'h195);
		repeat (TO - 20) @(negedge clk_i);
		chk(12'(alert_o), 12'h0);
		repeat (30) @(negedge clk_i);
		chk(12'(alert_o), 12'h1);
		sw(1'b0, 12'h195);
		chk(12'(alert_o), 12'h0);
		watchdog_enable_i = 1'b0;
		repeat (TO + 20) @(negedge clk_i);
		chk(12'(alert_o), 12'h0);
		// Frozen block must ignore a whole frame sent while the enable is low
		ce_i = 1'b0;
		wr(2'h3, dac_cfg_pkg::SEL_CHANNEL_CONTROL, 13'h0075);
		ce_i = 1'b1;
		repeat (4) @(negedge clk_i);
		chk_all();
		tally_and_finish();
	end
endmodule // dac_channel_config_and_soft_reg_test
